// File: bus_hold_pkg.sv
// Shared constants and state encoding for the local-bus hold and ready control
package bus_hold_pkg;

  // Bus controller states: idle, the four T-states, wait, granted, yielding
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_T1    = 3'h1,
    ST_T2    = 3'h2,
    ST_T3    = 3'h3,
    ST_TW    = 3'h4,
    ST_T4    = 3'h5,
    ST_HOLD  = 3'h6,
    ST_YIELD = 3'h7
  } bus_state_t;

  // Flip-flops on each pin input; a change counts when the last two agree
  localparam int unsigned PIN_SYNC_STAGES = 3;

  // Shortest bus cycle, T1 to T4 with no wait state, in clocks
  localparam int unsigned MIN_CYCLE_CLK = 4;

  // Worst hold latency behind an odd-to-odd DMA word transfer, no wait states
  localparam int unsigned DMA_ODD_WORD_LATENCY_CLK = 16;

  // Reset values: strobe pulled up inactive, flag pulled down, all floated
  localparam logic RD_N_RESET = 1'b1;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic OE_RESET = 1'b0;
  localparam logic ACK_RESET = 1'b0;

endpackage

// File: bus_hold_ctl.sv
// Local-bus ownership, read strobe, cycle status flag and ready control
//
// Overview of operation
// - A pending refresh wins over a hold request; hold wins over other cycles.
// - Hold waits for the running cycle to end, up to one bus cycle plus waits.
// - No grant while a locked sequence runs; refreshes may delay it further.
// - Read strobe asserts only after the muxed address/data bus has floated.
// - Read strobe floats, pulled inactive, while granted and during reset.
// - Cycle flag is high over T1 to T4 of DMA or refresh cycles only.
// - Cycle flag floats while granted and floats pulled low during reset.
// - Synchronous ready is sampled directly, with no synchroniser stage.
// - Asynchronous ready passes a synchroniser; the synchronous one does not.
// - Synchronous ready high means ready; low leaves asynchronous ready to decide.
// - On hold the current cycle ends, then acknowledge rises and outputs float.
// - Master drops its request to return the bus; acknowledge then drops.
// - Device drops acknowledge to reclaim the bus while the request stays high.
module bus_hold_ctl (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic HOLD_REQ_I,
  input wire logic SYNC_READY_IN_I,
  input wire logic ASYNC_READY_IN_I,
  input wire logic CYCLE_REQ_I,
  input wire logic CYCLE_READ_I,
  input wire logic CYCLE_DMA_I,
  input wire logic REFRESH_REQ_I,
  input wire logic LOCK_I,
  output logic BUS_GRANT_ACK_O,
  output logic BUS_OE_O,
  output logic MUXED_ADDR_DATA_BUS_OE_O,
  output logic READ_STROBE_N_O,
  output logic READ_STROBE_OE_O,
  output logic DMA_REFRESH_CYCLE_FLAG_O,
  output logic DMA_REFRESH_CYCLE_FLAG_OE_O,
  output logic CYCLE_START_O,
  output logic REFRESH_START_O,
  output logic CYCLE_DONE_O
);

  // Pin synchronisers for hold request and asynchronous ready
  logic [bus_hold_pkg::PIN_SYNC_STAGES-1:0] hold_sync_reg, hold_sync_next;
  logic [bus_hold_pkg::PIN_SYNC_STAGES-1:0] async_ready_in_sync_reg, async_ready_in_sync_next;
  logic hold_lvl_reg, hold_lvl_next;
  logic async_ready_in_lvl_reg, async_ready_in_lvl_next;

  // Controller state and cycle attributes
  bus_hold_pkg::bus_state_t st_reg, st_next;
  logic cyc_read_reg, cyc_read_next;
  logic cyc_flag_reg, cyc_flag_next;

  // Registered outputs
  logic ack_reg, ack_next;
  logic bus_oe_reg, bus_oe_next;
  logic ad_oe_reg, ad_oe_next;
  logic rd_n_reg, rd_n_next;
  logic rd_oe_reg, rd_oe_next;
  logic flag_reg, flag_next;
  logic flag_oe_reg, flag_oe_next;
  logic start_reg, start_next;
  logic ref_start_reg, ref_start_next;
  logic done_reg, done_next;

  // Combined ready seen in T3 and wait states
  logic ready;
  logic own_next;
  logic data_phase_next;

  // Shift both pins in; the level moves only when stages two and three agree
  always_comb begin
    hold_sync_next = {hold_sync_reg[1:0], HOLD_REQ_I};
    async_ready_in_sync_next = {async_ready_in_sync_reg[1:0], ASYNC_READY_IN_I};
    hold_lvl_next = hold_lvl_reg;
    async_ready_in_lvl_next = async_ready_in_lvl_reg;
    if (hold_sync_reg[1] == hold_sync_reg[2]) begin
      hold_lvl_next = hold_sync_reg[2];
    end
    if (async_ready_in_sync_reg[1] == async_ready_in_sync_reg[2]) begin
      async_ready_in_lvl_next = async_ready_in_sync_reg[2];
    end
  end

  // Synchroniser registers
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      hold_sync_reg <= '0;
      async_ready_in_sync_reg <= '0;
      hold_lvl_reg <= 1'b0;
      async_ready_in_lvl_reg <= 1'b0;
    end else begin
      hold_sync_reg <= hold_sync_next;
      async_ready_in_sync_reg <= async_ready_in_sync_next;
      hold_lvl_reg <= hold_lvl_next;
      async_ready_in_lvl_reg <= async_ready_in_lvl_next;
    end
  end

  // Synchronous ready is already aligned to our clock, so it skips the chain
  assign ready = SYNC_READY_IN_I | async_ready_in_lvl_reg;

  // Next state, cycle attributes and output values
  always_comb begin
    st_next = st_reg;
    cyc_read_next = cyc_read_reg;
    cyc_flag_next = cyc_flag_reg;
    start_next = 1'b0;
    ref_start_next = 1'b0;
    done_next = 1'b0;
    unique case (st_reg)
      bus_hold_pkg::ST_IDLE: begin
        // Decisions are made only between cycles, so a running cycle always ends
        if (REFRESH_REQ_I) begin
          st_next = bus_hold_pkg::ST_T1;
          cyc_read_next = 1'b1;
          cyc_flag_next = 1'b1;
          ref_start_next = 1'b1;
        end else if (hold_lvl_reg && !LOCK_I) begin
          st_next = bus_hold_pkg::ST_HOLD;
        end else if (CYCLE_REQ_I) begin
          // Pending DMA cycles wait here while a refresh or an unlocked hold is pending
          st_next = bus_hold_pkg::ST_T1;
          cyc_read_next = CYCLE_READ_I;
          cyc_flag_next = CYCLE_DMA_I;
          start_next = 1'b1;
        end
      end
      bus_hold_pkg::ST_T1: begin
        st_next = bus_hold_pkg::ST_T2;
      end
      bus_hold_pkg::ST_T2: begin
        st_next = bus_hold_pkg::ST_T3;
      end
      bus_hold_pkg::ST_T3, bus_hold_pkg::ST_TW: begin
        if (ready) begin
          st_next = bus_hold_pkg::ST_T4;
          done_next = 1'b1;
        end else begin
          st_next = bus_hold_pkg::ST_TW;
        end
      end
      bus_hold_pkg::ST_T4: begin
        st_next = bus_hold_pkg::ST_IDLE;
      end
      bus_hold_pkg::ST_HOLD: begin
        if (!hold_lvl_reg) begin
          st_next = bus_hold_pkg::ST_IDLE;
        end else if (REFRESH_REQ_I) begin
          st_next = bus_hold_pkg::ST_YIELD;
        end
      end
      bus_hold_pkg::ST_YIELD: begin
        // Outputs stay floated until the master has really let go
        if (!hold_lvl_reg) begin
          st_next = bus_hold_pkg::ST_IDLE;
        end
      end
    endcase

    own_next = (st_next != bus_hold_pkg::ST_HOLD) && (st_next != bus_hold_pkg::ST_YIELD);
    data_phase_next = (st_next == bus_hold_pkg::ST_T2) || (st_next == bus_hold_pkg::ST_T3) ||
                      (st_next == bus_hold_pkg::ST_TW) || (st_next == bus_hold_pkg::ST_T4);
    ack_next = (st_next == bus_hold_pkg::ST_HOLD);
    bus_oe_next = own_next;
    ad_oe_next = own_next && !(cyc_read_next && data_phase_next);
    // Strobe waits one clock after the float, trading a little timing for safety
    rd_n_next = !(cyc_read_next && !ad_oe_reg &&
                  ((st_next == bus_hold_pkg::ST_T3) || (st_next == bus_hold_pkg::ST_TW)));
    rd_oe_next = own_next;
    flag_next = own_next && cyc_flag_next &&
                ((st_next == bus_hold_pkg::ST_T1) || data_phase_next);
    flag_oe_next = own_next;
  end

  // State and output registers; reset floats everything with inactive levels
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      st_reg <= bus_hold_pkg::ST_IDLE;
      cyc_read_reg <= 1'b0;
      cyc_flag_reg <= 1'b0;
      ack_reg <= bus_hold_pkg::ACK_RESET;
      bus_oe_reg <= bus_hold_pkg::OE_RESET;
      ad_oe_reg <= bus_hold_pkg::OE_RESET;
      rd_n_reg <= bus_hold_pkg::RD_N_RESET;
      rd_oe_reg <= bus_hold_pkg::OE_RESET;
      flag_reg <= bus_hold_pkg::FLAG_RESET;
      flag_oe_reg <= bus_hold_pkg::OE_RESET;
      start_reg <= 1'b0;
      ref_start_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cyc_read_reg <= cyc_read_next;
      cyc_flag_reg <= cyc_flag_next;
      ack_reg <= ack_next;
      bus_oe_reg <= bus_oe_next;
      ad_oe_reg <= ad_oe_next;
      rd_n_reg <= rd_n_next;
      rd_oe_reg <= rd_oe_next;
      flag_reg <= flag_next;
      flag_oe_reg <= flag_oe_next;
      start_reg <= start_next;
      ref_start_reg <= ref_start_next;
      done_reg <= done_next;
    end
  end

  // Output ports straight from the registers
  assign BUS_GRANT_ACK_O = ack_reg;
  assign BUS_OE_O = bus_oe_reg;
  assign MUXED_ADDR_DATA_BUS_OE_O = ad_oe_reg;
  assign READ_STROBE_N_O = rd_n_reg;
  assign READ_STROBE_OE_O = rd_oe_reg;
  assign DMA_REFRESH_CYCLE_FLAG_O = flag_reg;
  assign DMA_REFRESH_CYCLE_FLAG_OE_O = flag_oe_reg;
  assign CYCLE_START_O = start_reg;
  assign REFRESH_START_O = ref_start_reg;
  assign CYCLE_DONE_O = done_reg;

  // Helper for the latency check: clocks a seen hold has waited, leaving out
  // wait states, locked spans, yielding and the restart that a refresh forces
  localparam logic [4:0] HOLD_WAIT_MAX = 5'(bus_hold_pkg::MIN_CYCLE_CLK + 1);
  logic [4:0] hold_wait_reg, hold_wait_next;
  always_comb begin
    hold_wait_next = hold_wait_reg;
    if (!hold_lvl_reg || ack_reg || LOCK_I || ref_start_reg ||
        (st_reg == bus_hold_pkg::ST_YIELD)) begin
      hold_wait_next = 5'h00;
    end else if ((st_reg != bus_hold_pkg::ST_TW) && (hold_wait_reg != 5'h1f)) begin
      hold_wait_next = hold_wait_reg + 5'h01; // Saturates so it never wraps
    end
  end

  // Latency helper register
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      hold_wait_reg <= 5'h00;
    end else begin
      hold_wait_reg <= hold_wait_next;
    end
  end

  // Checks on the controller
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  sequence s_cycle_head;
    st_reg == bus_hold_pkg::ST_T1 ##1 st_reg == bus_hold_pkg::ST_T2 ##1
    st_reg == bus_hold_pkg::ST_T3;
  endsequence

  sequence s_read_open;
    !ad_oe_reg ##1 !rd_n_reg;
  endsequence

  sequence s_cycle_tail;
    done_reg && (st_reg == bus_hold_pkg::ST_T4) ##1 st_reg == bus_hold_pkg::ST_IDLE;
  endsequence

  sequence s_bus_floated;
    !bus_oe_reg && !ad_oe_reg && !rd_oe_reg && !flag_oe_reg;
  endsequence

  a_refresh_first: assert property ((st_reg == bus_hold_pkg::ST_IDLE) && REFRESH_REQ_I |=>
    ref_start_reg && !ack_reg)
    else $error("Refresh did not win over hold");
  a_lock_blocks: assert property ($rose(ack_reg) |-> !$past(LOCK_I) &&
    $past(st_reg) == bus_hold_pkg::ST_IDLE)
    else $error("Grant inside a locked sequence or mid cycle");
  a_cycle_order: assert property ((start_reg || ref_start_reg) |-> s_cycle_head)
    else $error("Bus cycle states out of order");
  a_rd_after_float: assert property ($fell(rd_n_reg) |-> !$past(ad_oe_reg) &&
    !ad_oe_reg)
    else $error("Read strobe before the bus floated");
  a_rd_open_seq: assert property ((st_reg == bus_hold_pkg::ST_T2) && cyc_read_reg |->
    s_read_open)
    else $error("Read strobe not opened in T3");
  a_rd_hold_float: assert property (ack_reg |-> !rd_oe_reg && rd_n_reg && !bus_oe_reg)
    else $error("Read strobe driven while granted");
  a_flag_span: assert property ((start_reg || ref_start_reg) && cyc_flag_reg |->
    flag_reg [*4])
    else $error("Cycle flag dropped inside T1 to T4");
  a_flag_idle: assert property ((st_reg == bus_hold_pkg::ST_IDLE) |-> !flag_reg)
    else $error("Cycle flag high outside a cycle");
  a_flag_float: assert property (ack_reg |-> !flag_oe_reg && !flag_reg)
    else $error("Cycle flag driven while granted");
  a_sync_ready: assert property ((st_reg == bus_hold_pkg::ST_T3) && SYNC_READY_IN_I |=>
    done_reg ##1 st_reg == bus_hold_pkg::ST_IDLE)
    else $error("Synchronous ready did not end the cycle");
  a_async_wait: assert property ((st_reg == bus_hold_pkg::ST_TW) && !SYNC_READY_IN_I &&
    !async_ready_in_lvl_reg |=> st_reg == bus_hold_pkg::ST_TW)
    else $error("Cycle ended without ready");
  a_hold_release: assert property (ack_reg && !hold_lvl_reg |=> !ack_reg)
    else $error("Acknowledge held after request dropped");
  a_reclaim: assert property ((st_reg == bus_hold_pkg::ST_HOLD) && hold_lvl_reg &&
    REFRESH_REQ_I |=> !ack_reg && !bus_oe_reg)
    else $error("Acknowledge not dropped for refresh");
  a_grant_delay: assert property ($rose(hold_lvl_reg) &&
    (st_reg == bus_hold_pkg::ST_IDLE) && !LOCK_I && !REFRESH_REQ_I |=> ack_reg)
    else $error("Idle bus not granted");
  // Ready from the slow path alone must close the cycle
  a_async_ends: assert property (((st_reg == bus_hold_pkg::ST_T3) ||
    (st_reg == bus_hold_pkg::ST_TW)) && async_ready_in_lvl_reg |=> s_cycle_tail)
    else $error("Asynchronous ready did not end the cycle");
  a_write_no_rd: assert property (start_reg && !cyc_read_reg |-> rd_n_reg [*4])
    else $error("Read strobe in a write cycle");
  a_flag_cpu: assert property (start_reg && !cyc_flag_reg |-> !flag_reg [*4])
    else $error("Cycle flag high in a core cycle");
  a_hold_stops_core: assert property (hold_lvl_reg && !LOCK_I |=> !start_reg)
    else $error("Core cycle started over a hold request");
  a_grant_floats: assert property (ack_reg || (st_reg == bus_hold_pkg::ST_YIELD)
    |-> s_bus_floated)
    else $error("Bus driven while handed over");
  a_hold_latency: assert property (hold_wait_reg <= HOLD_WAIT_MAX)
    else $error("Hold request waited too long");

endmodule

// File: ext_master_model.sv
// External bus master and ready-giving target facing the hold controller
module ext_master_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic want_hold_i,
  input wire logic async_mode_i,
  input wire logic [3:0] waits_i,
  input wire logic ack_i,
  input wire logic start_i,
  input wire logic done_i,
  output logic hold_req_o,
  output logic sync_ready_o,
  output logic async_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic backed_off;
  logic ack_seen;
  logic taken_back;
  int cnt;
  assign taken_back = ack_seen && !ack_i && hold_req_o;
  // Falling-edge updates so the device samples settled levels; ready may stand between
  // cycles, where the device ignores it
  always @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_req_o <= 1'b0;
      backed_off <= 1'b0;
      ack_seen <= 1'b0;
      cnt <= 15;
      sync_ready_o <= 1'b0;
      async_ready_o <= 1'b0;
    end else begin
      ack_seen <= ack_i;
      if (taken_back) backed_off <= 1'b1;
      else if (!want_hold_i) backed_off <= 1'b0;
      hold_req_o <= want_hold_i && !backed_off && !taken_back;
      if (start_i) cnt <= 0;
      else if (cnt < 15) cnt <= cnt + 1;
      sync_ready_o <= !async_mode_i && !start_i && cnt < 15 && !done_i
                      && cnt + 1 >= 2 + int'(waits_i);
      async_ready_o <= async_mode_i && (start_i || cnt < 15) && !done_i;
    end
  end
endmodule

// File: bus_hold_ctl_tb.sv
// Self-checking bench for the local-bus hold and ready control
module bus_hold_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic want_hold = 1'b0;
  logic async_mode = 1'b0;
  logic [3:0] waits = 4'h0;
  logic c_req = 1'b0, c_read = 1'b0, c_dma = 1'b0, r_req = 1'b0, lock = 1'b0;
  logic hold_req, sready, aready, ack, bus_oe, ad_oe, rd_n, rd_oe, flag, flag_oe;
  logic c_start, r_start, done;
  int err_total = 0;
  int n_compared = 0;
  int n;
  always #10 clk = ~clk;
  bus_hold_ctl u_bus_hold_ctl (.CLK_SYS_I(clk), .RST_I(rst), .HOLD_REQ_I(hold_req),
    .SYNC_READY_IN_I(sready), .ASYNC_READY_IN_I(aready), .CYCLE_REQ_I(c_req),
    .CYCLE_READ_I(c_read), .CYCLE_DMA_I(c_dma), .REFRESH_REQ_I(r_req), .LOCK_I(lock),
    .BUS_GRANT_ACK_O(ack), .BUS_OE_O(bus_oe), .MUXED_ADDR_DATA_BUS_OE_O(ad_oe),
    .READ_STROBE_N_O(rd_n), .READ_STROBE_OE_O(rd_oe), .DMA_REFRESH_CYCLE_FLAG_O(flag),
    .DMA_REFRESH_CYCLE_FLAG_OE_O(flag_oe), .CYCLE_START_O(c_start),
    .REFRESH_START_O(r_start), .CYCLE_DONE_O(done));
  ext_master_model u_ext_master_model (.clk_i(clk), .rst_i(rst), .want_hold_i(want_hold),
    .async_mode_i(async_mode), .waits_i(waits), .ack_i(ack), .start_i(c_start | r_start),
    .done_i(done), .hold_req_o(hold_req), .sync_ready_o(sready), .async_ready_o(aready));
  // Closing report, reached from the main sequence or from a spent wait
  task automatic end_sim();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return ack;
      1: return c_start;
      2: return done;
      3: return r_start;
      default: return !ack;
    endcase
  endfunction
  // Bounded wait at falling edges; the strobe is watched against the bus float meanwhile
  task automatic wait_on(input int k, input int lim, output int cnt);
    cnt = 0;
    while (pick(k) !== 1'b1) begin
      @(negedge clk);
      cnt++;
      if (rd_n === 1'b0) chk_bit(ad_oe, 1'b0);
      if (cnt > lim) begin
        err_total++;
        end_sim();
      end
    end
  endtask
  task automatic run_cycle(input logic rd, input logic dma, output int lat);
    c_req = 1'b1;
    c_read = rd;
    c_dma = dma;
    wait_on(1, 8, lat);
    c_req = 1'b0;
    chk_bit(flag, dma);
    wait_on(2, 20, lat);
    chk_bit(flag, dma);
    @(negedge clk);
    chk_bit(flag, 1'b0);
  endtask
  task automatic t_reset();
    chk_bit(rd_oe, 1'b0);
    chk_bit(rd_n, 1'b1);
    chk_bit(flag_oe, 1'b0);
    chk_bit(flag, 1'b0);
    chk_bit(ack, 1'b0);
  endtask
  task automatic t_cycles();
    int lat;
    run_cycle(1'b1, 1'b0, lat);
    chk_cnt(lat, int'(bus_hold_pkg::MIN_CYCLE_CLK) - 1);
    run_cycle(1'b0, 1'b1, lat);
    chk_cnt(lat, int'(bus_hold_pkg::MIN_CYCLE_CLK) - 1);
    waits = 4'h2;
    run_cycle(1'b1, 1'b1, lat);
    chk_cnt(lat, int'(bus_hold_pkg::MIN_CYCLE_CLK) - 1 + int'(waits));
    waits = 4'h0;
    async_mode = 1'b1;
    run_cycle(1'b1, 1'b0, lat);
    chk_bit(lat > 3 && lat < 9, 1'b1);
    async_mode = 1'b0;
  endtask
  task automatic t_hold_idle();
    want_hold = 1'b1;
    wait_on(0, 10, n);
    chk_bit(rd_oe | bus_oe | ad_oe, 1'b0);
    chk_bit(rd_n, 1'b1);
    chk_bit(flag_oe, 1'b0);
    want_hold = 1'b0;
    wait_on(4, 8, n);
    @(negedge clk);
    chk_bit(bus_oe, 1'b1);
  endtask
  task automatic t_lock();
    lock = 1'b1;
    want_hold = 1'b1;
    repeat (12) @(negedge clk);
    chk_bit(ack, 1'b0);
    // A core cycle waits as well; the hold must win once the lock drops
    lock = 1'b0;
    c_req = 1'b1;
    c_read = 1'b0;
    wait_on(0, 4, n);
    chk_bit(c_start, 1'b0);
    want_hold = 1'b0;
    wait_on(4, 8, n);
    wait_on(1, 8, n);
    c_req = 1'b0;
    wait_on(2, 20, n);
    chk_cnt(n, int'(bus_hold_pkg::MIN_CYCLE_CLK) - 1);
    repeat (3) @(negedge clk);
  endtask
  // Hold and refresh both arrive mid-cycle; then the device reclaims a granted bus
  task automatic t_busy_refresh();
    waits = 4'h3;
    c_req = 1'b1;
    c_read = 1'b1;
    wait_on(1, 8, n);
    c_req = 1'b0;
    want_hold = 1'b1;
    r_req = 1'b1;
    wait_on(2, 20, n);
    chk_bit(ack, 1'b0);
    wait_on(3, 4, n);
    r_req = 1'b0;
    chk_bit(ack, 1'b0);
    chk_bit(flag, 1'b1);
    wait_on(0, int'(bus_hold_pkg::DMA_ODD_WORD_LATENCY_CLK), n);
    r_req = 1'b1;
    wait_on(4, 4, n);
    wait_on(3, 12, n);
    r_req = 1'b0;
    chk_bit(hold_req, 1'b0);
    want_hold = 1'b0;
    waits = 4'h0;
    repeat (8) @(negedge clk);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    t_reset();
    rst = 1'b0;
    @(negedge clk);
    t_cycles();
    t_hold_idle();
    t_lock();
    t_busy_refresh();
    end_sim();
  end
endmodule
